//--- verilog/asc_pkg.sv
// Purpose: constants and types for the scan sequencer control block
// Assumes: 8-bit control registers and 10-bit results in the low bits of each 32-bit Avalon word
// Notes: register offsets are word indexes, byte address is four times the index
package asc_pkg;

	localparam int ASC_ADDR_W = 24;
	localparam int ASC_RES_W = 10;

	// register word indexes
	localparam logic [23:0] ASC_SINGLE_SEL_IDX = 24'h800081;
	localparam logic [23:0] ASC_SCAN_CTRL_IDX = 24'h800084;
	localparam logic [23:0] ASC_SCAN_CFG_IDX = 24'h800085;
	localparam logic [23:0] ASC_RESULT_BASE_IDX = 24'h800090;

	// scan_control fields (bit n of the byte)
	localparam int ASC_CTRL_REPEAT_BIT = 6;
	localparam int ASC_CTRL_HWSRC_BIT = 5;
	localparam int ASC_CTRL_TRIG_BIT = 4;
	localparam int ASC_CTRL_REQ_BIT = 3;
	localparam int ASC_CTRL_DONE_BIT = 2;
	localparam int ASC_CTRL_STOP_BIT = 1;
	localparam int ASC_CTRL_START_BIT = 0;
	localparam logic [7:0] ASC_CTRL_RESET = 8'h04;

	// scan_config fields
	localparam int ASC_CFG_RATE_BIT = 6;
	localparam int ASC_CFG_LEN_HI = 3;
	localparam int ASC_CFG_LEN_LO = 2;
	localparam logic [7:0] ASC_CFG_RESET = 8'h00;

	// single select fields
	localparam int ASC_SEL_START_BIT = 7;
	localparam int ASC_SEL_EXP_BIT = 5;
	localparam logic [7:0] ASC_SEL_RESET = 8'h00;

	localparam logic [3:0] ASC_EXP_CHAN = 4'hF;
	localparam logic [1:0] ASC_LEN_4 = 2'h1;
	localparam logic [1:0] ASC_LEN_8 = 2'h2;

	typedef enum logic [1:0] {ASC_IDLE, ASC_SCAN, ASC_SINGLE, ASC_FORCED} asc_state_t;

	// last channel of a scan for a scan length code
	function automatic logic [3:0] asc_last_chan(input logic [1:0] len);
		if (len == ASC_LEN_4)
			return 4'h3;
		else if (len == ASC_LEN_8)
			return 4'h7;
		else
			return 4'hF;
	endfunction

endpackage

//--- verilog/asc_scan_ctrl.sv
// Purpose: scan and single sequencing for a successive-approximation converter
// Assumes: analog core takes conv_start_o, ends with conv_done_i and result
// Notes: one wait state on every Avalon access
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module asc_scan_ctrl
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// avalon slave
	input wire logic [asc_pkg::ASC_ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// trigger sources
	input wire logic external_trigger_pin_i,
	input wire logic timer_event3_i,
	// analog core
	output logic conv_start_o,
	output logic conv_abort_o,
	output logic [3:0] conv_chan_o,
	output logic conv_rate_o,
	input wire logic conv_done_i,
	input wire logic [asc_pkg::ASC_RES_W-1:0] conv_result_i,
	// requests and external selector
	output logic scan_irq_o,
	output logic scan_dma_o,
	output logic ext_selector_out0_o,
	output logic ext_selector_out1_o
);
	import asc_pkg::*;

	asc_state_t state_r;
	logic scan_repeat_select_r;
	logic scan_hw_source_select_r;
	logic scan_trigger_select_r;
	logic scan_irq_dma_select_r;
	logic scan_rate_select_r;
	logic [1:0] scan_len_r;
	logic input_expansion_enable_r;
	logic [3:0] single_channel_select_r;
	logic [3:0] scan_chan_r;
	logic busy_r;
	logic pend_scan_r;
	logic trig_pin_q_r;
	logic timer_q_r;
	logic [ASC_RES_W-1:0] result_r [16];
	logic [31:0] readdata_nxt;
	logic wr_ok;
	logic wr_ctrl;
	logic wr_cfg;
	logic wr_sel;
	logic stop_w;
	logic sw_start;
	logic hw_evt;
	logic single_start;
	logic scan_go;
	logic [3:0] single_chan;
	logic [3:0] last_chan;
	logic scanning;

	assign wr_ok = write_i && !waitrequest_o && byteenable_i[0];
	assign wr_ctrl = wr_ok && (address_i == ASC_SCAN_CTRL_IDX);
	assign wr_cfg = wr_ok && (address_i == ASC_SCAN_CFG_IDX);
	assign wr_sel = wr_ok && (address_i == ASC_SINGLE_SEL_IDX);
	assign stop_w = wr_ctrl && writedata_i[ASC_CTRL_STOP_BIT];
	// stop in the same write cancels the start
	assign sw_start = wr_ctrl && writedata_i[ASC_CTRL_START_BIT] && !stop_w
		&& !scan_trigger_select_r;
	// falling edge of the pin, so a held low pin launches nothing more
	assign hw_evt = scan_hw_source_select_r ? (timer_event3_i && !timer_q_r)
		: (!external_trigger_pin_i && trig_pin_q_r);
	assign single_start = wr_sel && writedata_i[ASC_SEL_START_BIT];
	assign scan_go = sw_start || (scan_trigger_select_r && hw_evt);
	assign single_chan = input_expansion_enable_r ? ASC_EXP_CHAN
		: single_channel_select_r;
	assign last_chan = asc_last_chan(scan_len_r);
	assign scanning = (state_r == ASC_SCAN) || (state_r == ASC_FORCED);

	// avalon handshake, one wait state
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			waitrequest_o <= 1'b1;
		else
			waitrequest_o <= !((read_i || write_i) && waitrequest_o);
	end

	always_comb
	begin
		readdata_nxt = 32'h00000000;
		if (address_i == ASC_SCAN_CTRL_IDX)
		begin
			readdata_nxt[ASC_CTRL_REPEAT_BIT] = scan_repeat_select_r;
			readdata_nxt[ASC_CTRL_HWSRC_BIT] = scan_hw_source_select_r;
			readdata_nxt[ASC_CTRL_TRIG_BIT] = scan_trigger_select_r;
			readdata_nxt[ASC_CTRL_REQ_BIT] = scan_irq_dma_select_r;
			readdata_nxt[ASC_CTRL_DONE_BIT] = !scanning;
		end
		else if (address_i == ASC_SCAN_CFG_IDX)
		begin
			readdata_nxt[ASC_CFG_RATE_BIT] = scan_rate_select_r;
			if (scanning)
				readdata_nxt[3:0] = scan_chan_r;
			else if (state_r == ASC_SINGLE)
				readdata_nxt[3:0] = 4'h0;
			else
				readdata_nxt[ASC_CFG_LEN_HI:ASC_CFG_LEN_LO] = scan_len_r;
		end
		else if (address_i == ASC_SINGLE_SEL_IDX)
		begin
			readdata_nxt[ASC_SEL_EXP_BIT] = input_expansion_enable_r;
			readdata_nxt[3:0] = single_channel_select_r;
		end
		else if (address_i[23:4] == ASC_RESULT_BASE_IDX[23:4])
		begin
			readdata_nxt[ASC_RES_W-1:0] = result_r[address_i[3:0]];
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			readdata_o <= 32'h00000000;
		else if (read_i && waitrequest_o)
			readdata_o <= readdata_nxt;
	end

	// configuration registers
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			scan_repeat_select_r <= ASC_CTRL_RESET[ASC_CTRL_REPEAT_BIT];
			scan_hw_source_select_r <= ASC_CTRL_RESET[ASC_CTRL_HWSRC_BIT];
			scan_trigger_select_r <= ASC_CTRL_RESET[ASC_CTRL_TRIG_BIT];
			scan_irq_dma_select_r <= ASC_CTRL_RESET[ASC_CTRL_REQ_BIT];
			scan_rate_select_r <= ASC_CFG_RESET[ASC_CFG_RATE_BIT];
			scan_len_r <= ASC_CFG_RESET[ASC_CFG_LEN_HI:ASC_CFG_LEN_LO];
			input_expansion_enable_r <= ASC_SEL_RESET[ASC_SEL_EXP_BIT];
			single_channel_select_r <= ASC_SEL_RESET[3:0];
		end
		else
		begin
			if (wr_ctrl)
			begin
				scan_repeat_select_r <= writedata_i[ASC_CTRL_REPEAT_BIT];
				scan_hw_source_select_r <= writedata_i[ASC_CTRL_HWSRC_BIT];
				scan_trigger_select_r <= writedata_i[ASC_CTRL_TRIG_BIT];
				scan_irq_dma_select_r <= writedata_i[ASC_CTRL_REQ_BIT];
			end
			if (wr_cfg)
			begin
				scan_rate_select_r <= writedata_i[ASC_CFG_RATE_BIT];
				// low two field bits are not stored
				scan_len_r <= writedata_i[ASC_CFG_LEN_HI:ASC_CFG_LEN_LO];
			end
			if (wr_sel)
			begin
				input_expansion_enable_r <= writedata_i[ASC_SEL_EXP_BIT];
				single_channel_select_r <= writedata_i[3:0];
			end
		end
	end

	// trigger edge history and selector outputs
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trig_pin_q_r <= 1'b1;
			timer_q_r <= 1'b0;
			ext_selector_out0_o <= 1'b0;
			ext_selector_out1_o <= 1'b0;
		end
		else
		begin
			trig_pin_q_r <= external_trigger_pin_i;
			timer_q_r <= timer_event3_i;
			ext_selector_out0_o <= input_expansion_enable_r && single_channel_select_r[1];
			ext_selector_out1_o <= input_expansion_enable_r && single_channel_select_r[0];
		end
	end

	// result registers
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 16; i++)
				result_r[i] <= '0;
		end
		else if (conv_done_i && busy_r && !stop_w && !sw_start && !single_start)
		begin
			if (state_r == ASC_SCAN)
				result_r[scan_chan_r] <= conv_result_i;
			else if (state_r != ASC_IDLE)
				result_r[single_chan] <= conv_result_i;
		end
	end

	// sequencer
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r <= ASC_IDLE;
			scan_chan_r <= 4'h0;
			busy_r <= 1'b0;
			pend_scan_r <= 1'b0;
			conv_start_o <= 1'b0;
			conv_abort_o <= 1'b0;
			conv_chan_o <= 4'h0;
			conv_rate_o <= 1'b0;
			scan_irq_o <= 1'b0;
			scan_dma_o <= 1'b0;
		end
		else
		begin
			conv_start_o <= 1'b0;
			conv_abort_o <= 1'b0;
			scan_irq_o <= 1'b0;
			scan_dma_o <= 1'b0;
			case (state_r)
				ASC_IDLE:
				begin
					busy_r <= 1'b0;
					if (scan_go)
					begin
						state_r <= ASC_SCAN;
						scan_chan_r <= 4'h0;
					end
					else if (single_start)
						state_r <= ASC_SINGLE;
				end
				ASC_SCAN:
				begin
					if (stop_w)
					begin
						conv_abort_o <= busy_r;
						busy_r <= 1'b0;
						state_r <= ASC_IDLE;
					end
					else if (sw_start)
					begin
						conv_abort_o <= busy_r;
						busy_r <= 1'b0;
						scan_chan_r <= 4'h0;
					end
					else if (single_start)
					begin
						conv_abort_o <= busy_r;
						busy_r <= 1'b0;
						state_r <= ASC_FORCED;
					end
					else if (!busy_r)
					begin
						conv_start_o <= 1'b1;
						conv_chan_o <= scan_chan_r;
						conv_rate_o <= scan_rate_select_r;
						busy_r <= 1'b1;
					end
					else if (conv_done_i)
					begin
						busy_r <= 1'b0;
						if (scan_chan_r == last_chan)
						begin
							scan_irq_o <= !scan_irq_dma_select_r;
							scan_dma_o <= scan_irq_dma_select_r;
							scan_chan_r <= 4'h0;
							if (!scan_repeat_select_r)
								state_r <= ASC_IDLE;
						end
						else
							scan_chan_r <= scan_chan_r + 4'h1;
					end
				end
				ASC_SINGLE:
				begin
					// scan stop leaves the state alone; in the done cycle it blocks the result write
					if (sw_start)
						pend_scan_r <= 1'b1;
					if (single_start)
					begin
						conv_abort_o <= busy_r;
						busy_r <= 1'b0;
					end
					else if (!busy_r)
					begin
						conv_start_o <= 1'b1;
						conv_chan_o <= single_chan;
						conv_rate_o <= 1'b0;
						busy_r <= 1'b1;
					end
					else if (conv_done_i)
					begin
						busy_r <= 1'b0;
						pend_scan_r <= 1'b0;
						scan_chan_r <= 4'h0;
						state_r <= (pend_scan_r || sw_start) ? ASC_SCAN : ASC_IDLE;
					end
				end
				ASC_FORCED:
				begin
					if (sw_start)
					begin
						conv_abort_o <= busy_r;
						busy_r <= 1'b0;
						scan_chan_r <= 4'h0;
						state_r <= ASC_SCAN;
					end
					else if (!busy_r)
					begin
						conv_start_o <= 1'b1;
						conv_chan_o <= single_chan;
						conv_rate_o <= 1'b0;
						busy_r <= 1'b1;
					end
					else if (conv_done_i)
					begin
						busy_r <= 1'b0;
						state_r <= ASC_SCAN; // resume cancelled channel
					end
				end
				default:
				begin
					state_r <= ASC_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

endmodule

//--- sim/asc_scan_chk.sv
// Purpose: port checks for asc_scan_ctrl
// Assumes: one clock, async reset
// Notes: bound from the bench top
`timescale 1ns/1ps
module asc_scan_chk
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// watched ports
	input wire logic read_i,
	input wire logic write_i,
	input wire logic waitrequest_o,
	input wire logic conv_start_o,
	input wire logic conv_abort_o,
	input wire logic [3:0] conv_chan_o,
	input wire logic conv_rate_o,
	input wire logic conv_done_i,
	input wire logic scan_irq_o,
	input wire logic scan_dma_o,
	input wire logic ext_selector_out0_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		(read_i || write_i) && waitrequest_o;
	endsequence
	sequence s_ans;
		!waitrequest_o ##1 waitrequest_o;
	endsequence
	property p_wait;
		s_req |=> s_ans;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	property p_excl;
		!(scan_irq_o && scan_dma_o);
	endproperty
	a_excl: assert property (p_excl) else $error("irq and dma");
	property p_cause;
		(scan_irq_o || scan_dma_o) |-> $past(conv_done_i);
	endproperty
	a_cause: assert property (p_cause) else $error("request without done");
	property p_req1;
		(scan_irq_o || scan_dma_o) |=> !(scan_irq_o || scan_dma_o);
	endproperty
	a_req1: assert property (p_req1) else $error("request too long");
	property p_start1;
		conv_start_o |=> !conv_start_o;
	endproperty
	a_start1: assert property (p_start1) else $error("start too long");
	property p_chan;
		!conv_start_o |-> $stable(conv_chan_o);
	endproperty
	a_chan: assert property (p_chan) else $error("channel moved");
	property p_rate;
		!conv_start_o |-> $stable(conv_rate_o);
	endproperty
	a_rate: assert property (p_rate) else $error("rate moved");
	property p_abort1;
		conv_abort_o |-> !conv_start_o ##1 !conv_abort_o;
	endproperty
	a_abort1: assert property (p_abort1) else $error("abort pulse");
	property p_sel;
		$changed(ext_selector_out0_o) |-> $past(write_i && !waitrequest_o, 2);
	endproperty
	a_sel: assert property (p_sel) else $error("selector moved");
endmodule

//--- sim/asc_core_model.sv
// Purpose: analog core stand-in
// Assumes: done lat_i cycles after start
// Notes: result toggles outside done
`timescale 1ns/1ps
module asc_core_model
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// control
	input wire logic [7:0] lat_i,
	input wire logic conv_start_i,
	input wire logic conv_abort_i,
	input wire logic [3:0] conv_chan_i,
	// answer
	output logic conv_done_o,
	output logic [9:0] conv_result_o
);
	logic [7:0] cnt_r;
	logic junk_r;
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			cnt_r <= 8'h00;
		else if (conv_start_i)
			cnt_r <= lat_i;
		else if (conv_abort_i)
			cnt_r <= 8'h00;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
	end
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			junk_r <= 1'b0;
		else
			junk_r <= ~junk_r;
	end
	assign conv_done_o = cnt_r == 8'h01;
	assign conv_result_o = conv_done_o ? {conv_chan_i, 6'h2A} : {10{junk_r}};
endmodule

//--- sim/asc_scan_ctrl_tb.sv
// Purpose: self-checking bench for asc_scan_ctrl
// Assumes: core model answers after lat cycles
// Notes: register rows first, then sequencing
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: %h %h", $time, g, e); end end
module asc_scan_ctrl_tb;
	import asc_pkg::*;
	typedef struct packed {logic wr; logic [23:0] a; logic [7:0] d;} asc_row_t;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [23:0] address_i = 24'h0;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic external_trigger_pin_i = 1'b1;
	logic timer_event3_i = 1'b0;
	logic [7:0] lat = 8'h10;
	logic [31:0] readdata_o;
	logic [31:0] rd;
	logic waitrequest_o, conv_start_o, conv_abort_o, conv_rate_o, conv_done_i;
	logic scan_irq_o, scan_dma_o, ext_selector_out0_o, ext_selector_out1_o;
	logic [3:0] conv_chan_o;
	logic [9:0] conv_result_i;
	int num_errors = 0;
	int checks_done = 0;
	int starts = 0;
	int irqs = 0;
	int dmas = 0;
	int cyc = 0;
	int s0;
	asc_row_t rows [7] = '{'{1'b0, ASC_SCAN_CTRL_IDX, ASC_CTRL_RESET},
		'{1'b0, ASC_SCAN_CFG_IDX, ASC_CFG_RESET}, '{1'b1, ASC_SCAN_CFG_IDX, 8'hFF},
		'{1'b0, ASC_SCAN_CFG_IDX, 8'h4C}, '{1'b1, ASC_SINGLE_SEL_IDX, 8'h2E},
		'{1'b0, ASC_SINGLE_SEL_IDX, 8'h2E}, '{1'b0, 24'h800082, 8'h00}};
	asc_scan_ctrl asc_scan_ctrl_i (.mclk_i, .rst_i, .address_i, .read_i, .write_i,
		.byteenable_i(4'hF), .writedata_i, .readdata_o, .waitrequest_o,
		.external_trigger_pin_i, .timer_event3_i, .conv_start_o, .conv_abort_o,
		.conv_chan_o, .conv_rate_o, .conv_done_i, .conv_result_i, .scan_irq_o,
		.scan_dma_o, .ext_selector_out0_o, .ext_selector_out1_o);
	asc_core_model asc_core_model_i (.mclk_i, .rst_i, .lat_i(lat),
		.conv_start_i(conv_start_o), .conv_abort_i(conv_abort_o),
		.conv_chan_i(conv_chan_o), .conv_done_o(conv_done_i),
		.conv_result_o(conv_result_i));
	initial
	begin
		forever #12.5 mclk_i = ~mclk_i;
	end
	always @(negedge mclk_i)
	begin
		cyc++;
		starts += (conv_start_o === 1'b1);
		irqs += (scan_irq_o === 1'b1);
		dmas += (scan_dma_o === 1'b1);
		if (cyc == 20000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (num_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [23:0] a, input logic [7:0] d);
		address_i <= a;
		writedata_i <= {24'h0, d};
		write_i <= wr;
		read_i <= !wr;
		do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
		rd = readdata_o;
		write_i <= 1'b0;
		read_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	initial
	begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		`CHK({waitrequest_o, conv_start_o}, 2'h2)
		foreach (rows[i])
		begin
			bus(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr)
				`CHK(rd, {24'h0, rows[i].d})
		end
		`CHK({ext_selector_out1_o, ext_selector_out0_o}, 2'h1)
		bus(1'b1, ASC_SINGLE_SEL_IDX, 8'hAD);
		wait (conv_start_o === 1'b1);
		@(negedge mclk_i);
		`CHK(conv_chan_o, ASC_EXP_CHAN)
		wait (conv_done_i === 1'b1);
		@(posedge mclk_i);
		bus(1'b0, ASC_RESULT_BASE_IDX + 24'hF, 8'h00);
		`CHK(rd, {22'h0, ASC_EXP_CHAN, 6'h2A})
		bus(1'b1, ASC_SINGLE_SEL_IDX, 8'h0D);
		@(posedge mclk_i);
		`CHK({ext_selector_out1_o, ext_selector_out0_o}, 2'h0)
		s0 = starts;
		bus(1'b1, ASC_SCAN_CFG_IDX, 8'h44);
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h01);
		bus(1'b0, ASC_SCAN_CTRL_IDX, 8'h00);
		`CHK(rd[2], 1'b0)
		bus(1'b0, ASC_SCAN_CFG_IDX, 8'h00);
		`CHK({rd, conv_rate_o}, {32'h40, 1'b1})
		wait (irqs == 1);
		repeat (40) @(posedge mclk_i);
		`CHK(starts, s0 + 4)
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, ASC_RESULT_BASE_IDX + 24'(i), 8'h00);
			`CHK(rd, {22'h0, 4'(i), 6'h2A})
		end
		lat <= 8'h04;
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h49);
		wait (dmas == 2);
		@(posedge mclk_i);
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h4A);
		s0 = starts;
		repeat (30) @(posedge mclk_i);
		bus(1'b0, ASC_SCAN_CTRL_IDX, 8'h00);
		`CHK({starts, irqs, rd[2]}, {s0, 32'd1, 1'b1})
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h01);
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h03);
		s0 = starts;
		repeat (30) @(posedge mclk_i);
		`CHK({starts, irqs}, {s0, 32'd1})
		lat <= 8'h08;
		s0 = starts;
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h01);
		wait (starts == s0 + 2);
		@(posedge mclk_i);
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h01);
		wait (irqs == 2);
		@(posedge mclk_i);
		`CHK(starts, s0 + 6)
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h30);
		timer_event3_i <= 1'b1;
		@(posedge mclk_i);
		timer_event3_i <= 1'b0;
		wait (irqs == 3);
		@(posedge mclk_i);
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h11);
		repeat (40) @(posedge mclk_i);
		`CHK(starts, s0 + 10)
		external_trigger_pin_i <= 1'b0;
		wait (irqs == 4);
		repeat (60) @(posedge mclk_i);
		`CHK(starts, s0 + 14)
		// eight channel single scan
		bus(1'b1, ASC_SCAN_CFG_IDX, 8'h08);
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h00);
		s0 = starts;
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h01);
		wait (irqs == 5);
		repeat (20) @(posedge mclk_i);
		`CHK(starts, s0 + 8)
		bus(1'b0, ASC_RESULT_BASE_IDX + 24'h7, 8'h00);
		`CHK(rd, {22'h0, 4'h7, 6'h2A})
		// forced single in a continuous scan
		s0 = starts;
		bus(1'b1, ASC_SCAN_CTRL_IDX, 8'h41);
		wait (starts == s0 + 3);
		@(posedge mclk_i);
		bus(1'b1, ASC_SINGLE_SEL_IDX, 8'h80);
		bus(1'b0, ASC_SCAN_CFG_IDX, 8'h00);
		`CHK(rd, 32'h02)
		wait (starts == s0 + 5);
		@(negedge mclk_i);
		`CHK(conv_chan_o, 4'h2)
		// reset in mid scan
		@(posedge mclk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		`CHK({waitrequest_o, conv_start_o, scan_irq_o}, 3'h4)
		s0 = starts;
		bus(1'b0, ASC_SCAN_CTRL_IDX, 8'h00);
		`CHK(rd, {24'h0, ASC_CTRL_RESET})
		repeat (20) @(posedge mclk_i);
		`CHK(starts, s0)
		wrap_up();
	end
endmodule
bind asc_scan_ctrl asc_scan_chk asc_scan_chk_i (.mclk_i, .rst_i, .read_i, .write_i,
	.waitrequest_o, .conv_start_o, .conv_abort_o, .conv_chan_o, .conv_rate_o,
	.conv_done_i, .scan_irq_o, .scan_dma_o, .ext_selector_out0_o);
